// File: core/tdpc_top.sv
`timescale 1ns/100ps
`default_nettype none
module tdpc_top
  import tdpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins from the board.
  input wire logic master_reset_n_i,
  input wire logic bc_trigger_in_i,
  input wire logic monitor_run_in_i,
  input wire logic irq_ack_in_i,
  input wire logic byte_order_pin_i,
  input wire logic bus_width_pin_i,
  input wire logic [NUM_RT-1:0] rt_enable_pin_i,
  input wire logic [NUM_RT-1:0] rt_lock_pin_i,
  input wire logic [NUM_RT-1:0][RTA_W-1:0] rt_address_pins_i,
  input wire logic [NUM_RT-1:0] rt_addr_parity_pin_i,
  input wire logic [NUM_RT-1:0] rt_subsys_fail_in_i,
  // Host word or byte requests, already on this clock.
  input wire tdpc_hreq_s host_req_i,
  input wire logic host_spi_i,
  output logic [WORD_W-1:0] host_rdata_o,
  output logic host_ack_o,
  // Events from the protocol engines.
  input wire logic irq_event_i,
  input wire logic mon_msg_busy_i,
  input wire logic mon_packet_done_i,
  input wire logic [NUM_RT-1:0] rt_mode_reset_i,
  input wire logic [NUM_RT-1:0] rt_status_done_i,
  // Results toward the engines and the pins.
  output logic bc_trigger_o,
  output logic monitor_record_o,
  output logic monitor_packet_ready_o,
  output logic irq_n_o,
  output logic [NUM_RT-1:0] rt_enable_o,
  output logic [NUM_RT-1:0] rt_start_exec_o,
  output logic [NUM_RT-1:0][RTA_W-1:0] rt_address_o,
  output logic [NUM_RT-1:0] rt_subsys_fail_o,
  output logic [NUM_RT-1:0] rt_reset_cmd_out_n_o
);

  localparam int SYNC_W = 6 + NUM_RT * (4 + RTA_W);

  // True when a host word offset hits a given register.
  function automatic logic hit(input logic [WOFF_W-1:0] a, input logic [WOFF_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic mr_s;
  logic trig_s;
  logic run_s;
  logic ack_s;
  logic bo_s;
  logic bw_s;
  logic [NUM_RT-1:0] en_s;
  logic [NUM_RT-1:0] lock_s;
  logic [NUM_RT-1:0][RTA_W-1:0] addr_s;
  logic [NUM_RT-1:0] par_s;
  logic [NUM_RT-1:0] ssf_s;

  // Every pin passes two flops before anything looks at it.
  assign pins_raw = {master_reset_n_i, bc_trigger_in_i, monitor_run_in_i, irq_ack_in_i,
                     byte_order_pin_i, bus_width_pin_i, rt_enable_pin_i, rt_lock_pin_i,
                     rt_address_pins_i, rt_addr_parity_pin_i, rt_subsys_fail_in_i};
  assign {mr_s, trig_s, run_s, ack_s, bo_s, bw_s, en_s, lock_s, addr_s, par_s, ssf_s} = pins_s;

  tdpc_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pins_raw),
    .sync_o(pins_s)
  );

  // Master reset edge tracking on the synchronised level.
  logic mr_q;
  logic mr_active;
  logic mr_rise;
  assign mr_active = ~mr_s;
  assign mr_rise = mr_s & ~mr_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mr_q <= 1'b0;
    end else begin
      mr_q <= mr_s;
    end
  end

  // Host side: a word bus, or a byte stream for the narrow bus and SPI.
  logic byte_mode;
  logic a0;
  logic low_first;
  logic [WOFF_W-1:0] woff;
  logic [BYTE_W-1:0] hold_q;
  logic [WORD_W-1:0] snap_q;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] wr_word;
  logic word_we;
  logic byte_rd;
  logic [BYTE_W-1:0] first_byte;
  logic [BYTE_W-1:0] second_byte;

  assign byte_mode = host_spi_i | ~bw_s;
  assign a0 = byte_mode & host_req_i.addr[0];
  assign low_first = ~bo_s;
  assign woff = host_req_i.addr[WORD_W-1:1];

  // The second byte completes the word; writes are lost during master reset.
  assign wr_word = !byte_mode ? host_req_i.wdata :
                   low_first ? {host_req_i.wdata[BYTE_W-1:0], hold_q} :
                   {hold_q, host_req_i.wdata[BYTE_W-1:0]};
  assign word_we = host_req_i.req & host_req_i.we & (!byte_mode | a0) & ~mr_active;
  assign byte_rd = host_req_i.req & ~host_req_i.we & byte_mode;

  // The even byte address holds the low byte while the byte order pin is low, and the high byte while it is high.
  assign first_byte = low_first ? rd_word[BYTE_W-1:0] : rd_word[WORD_W-1:BYTE_W];
  assign second_byte = low_first ? snap_q[WORD_W-1:BYTE_W] : snap_q[BYTE_W-1:0];

  // Byte hold and read snapshot keep both halves of one word together.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= '0;
      snap_q <= '0;
    end else begin
      if (host_req_i.req && host_req_i.we && byte_mode && !a0) begin
        hold_q <= host_req_i.wdata[BYTE_W-1:0];
      end
      if (byte_rd && !a0) begin
        snap_q <= rd_word;
      end
    end
  end

  // Master configuration register.
  tdpc_mcfg_s mcfg_q;
  logic mcfg_we;
  assign mcfg_we = word_we & hit(woff, OFF_MCFG);

  always_ff @(posedge clk_i) begin
    if (rst_i || mr_active) begin
      mcfg_q <= tdpc_mcfg_s'(MCFG_RST);
    end else if (mcfg_we) begin
      mcfg_q <= tdpc_mcfg_s'(wr_word);
    end
  end

  // Remote terminal slices.
  tdpc_opstat_s [NUM_RT-1:0] opstat;
  tdpc_stbits_s [NUM_RT-1:0] stbits;
  logic [NUM_RT-1:0] op_we;
  logic [NUM_RT-1:0] sb_we;

  for (genvar i = 0; i < NUM_RT; i++) begin : g_rt
    assign op_we[i] = word_we & hit(woff, OFF_OPSTAT0 + WOFF_W'(i));
    assign sb_we[i] = word_we & hit(woff, OFF_STBITS0 + WOFF_W'(i));
    // The terminal answers to its latched address, not the pins.
    assign rt_address_o[i] = opstat[i].addr;

    tdpc_rt u_rt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .mr_active_i(mr_active),
      .mr_rise_i(mr_rise),
      .lock_s_i(lock_s[i]),
      .addr_s_i(addr_s[i]),
      .parity_s_i(par_s[i]),
      .ssf_s_i(ssf_s[i]),
      .op_we_i(op_we[i]),
      .sb_we_i(sb_we[i]),
      .wdata_i(wr_word),
      .mode_reset_i(rt_mode_reset_i[i]),
      .status_done_i(rt_status_done_i[i]),
      .opstat_o(opstat[i]),
      .stbits_o(stbits[i]),
      .ssf_o(rt_subsys_fail_o[i]),
      .reset_cmd_n_o(rt_reset_cmd_out_n_o[i])
    );
  end

  // Read decode; unmapped words read as zero.
  logic [WORD_W-1:0] mtstat;
  assign mtstat = {12'h000, ~irq_n_o, mcfg_q.irq_level_select,
                   monitor_packet_ready_o, monitor_record_o};
  assign rd_word = hit(woff, OFF_MCFG) ? WORD_W'(mcfg_q) :
                   hit(woff, OFF_OPSTAT0) ? WORD_W'(opstat[0]) :
                   hit(woff, OFF_OPSTAT0 + WOFF_W'(1)) ? WORD_W'(opstat[1]) :
                   hit(woff, OFF_STBITS0) ? WORD_W'(stbits[0]) :
                   hit(woff, OFF_STBITS0 + WOFF_W'(1)) ? WORD_W'(stbits[1]) :
                   hit(woff, OFF_MTSTAT) ? mtstat : ZERO_WORD;

  // Every request is answered on the next edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_ack_o <= 1'b0;
      host_rdata_o <= ZERO_WORD;
    end else begin
      host_ack_o <= host_req_i.req;
      if (host_req_i.req && !host_req_i.we) begin
        host_rdata_o <= !byte_mode ? rd_word :
                        {8'h00, a0 ? second_byte : first_byte};
      end
    end
  end

  // Terminal enables and start bits. The start bit only passes while
  // the combined enable is high, so a premature start stays inert.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rt_enable_o <= '0;
      rt_start_exec_o <= '0;
      bc_trigger_o <= 1'b0;
    end else begin
      rt_enable_o <= en_s & mcfg_q.rt_enable_bit;
      rt_start_exec_o <= mcfg_q.rt_start_exec & en_s & mcfg_q.rt_enable_bit;
      bc_trigger_o <= trig_s;
    end
  end

  // Monitor run/stop. Packet ready clears only when run drops or master reset is active, so a
  // finished packet needs a run cycle from the host to restart.
  logic pkt_end;
  logic run_start;
  logic stop_now;
  logic rec_d;
  logic pkrdy_d;
  assign pkt_end = monitor_record_o & mon_packet_done_i;
  assign run_start = run_s & ~monitor_packet_ready_o;
  assign stop_now = ~run_s & ~mon_msg_busy_i;
  assign rec_d = pkt_end ? 1'b0 : run_start ? 1'b1 :
                 stop_now ? 1'b0 : monitor_record_o;
  assign pkrdy_d = pkt_end ? 1'b1 : run_s ? monitor_packet_ready_o : 1'b0;

  always_ff @(posedge clk_i) begin
    if (rst_i || mr_active) begin
      monitor_record_o <= 1'b0;
      monitor_packet_ready_o <= 1'b0;
    end else begin
      monitor_record_o <= rec_d;
      monitor_packet_ready_o <= pkrdy_d;
    end
  end

  // Interrupt request. A new event wins over an acknowledge in the
  // same cycle so it is never lost.
  logic ack_q;
  logic ack_rise;
  logic lvl;
  logic [CNT_W-1:0] icnt_q;
  logic [CNT_W-1:0] icnt_d;
  logic irq_n_d;
  assign lvl = mcfg_q.irq_level_select;
  assign ack_rise = lvl & ack_s & ~ack_q;
  assign icnt_d = irq_event_i ? CNT_W'(IRQ_PULSE_CYC - 1) :
                  (icnt_q != CNT_ZERO) ? icnt_q - CNT_ONE : icnt_q;
  assign irq_n_d = irq_event_i ? 1'b0 :
                   lvl ? (ack_rise ? 1'b1 : irq_n_o) :
                   (icnt_q == CNT_ZERO) ? 1'b1 : irq_n_o;

  always_ff @(posedge clk_i) begin
    if (rst_i || mr_active) begin
      ack_q <= 1'b0;
      icnt_q <= CNT_ZERO;
      irq_n_o <= 1'b1;
    end else begin
      ack_q <= ack_s;
      icnt_q <= icnt_d;
      irq_n_o <= irq_n_d;
    end
  end

endmodule : tdpc_top
`default_nettype wire

// File: core/tdpc_pkg.sv
// Overview of operation
// - High trigger pin means trigger condition true.
// - Monitor records while run input is high.
// - Run low stops monitor after current message.
// - Terminal enable is pin AND config bit.
// - Reset release latches lock pin into status.
// - Locked status register keeps its terminal address.
// - Unlocked status register takes address, parity, lock.
// - Reset command pulses low 100ns, reset-proof.
// - Subsystem fail is pin OR status bit.
// - Packet ready rises exactly as monitor stops.
// - Every enabled interrupt event drives request low.
// - Config bit selects pulse or level interrupt.
// - Level interrupt holds until acknowledge rising edge.
// - Reset release latches address and parity pins.
// - Terminal uses latched address, not pins.
// - Stored words are big-endian internally.
// - Byte order pin picks first parallel byte.
// - Byte order pin picks first serial byte.
// - Words move whole or as two bytes.
// - Master reset is active low, rising releases.
package tdpc_pkg;

  localparam int CLK_MHZ = 100;
  localparam int NS_PER_US = 1000;
  localparam int RST_CMD_NS = 100;
  localparam int RST_CMD_CYC = (RST_CMD_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int IRQ_PULSE_NS = 100;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int CNT_W = 8;
  localparam int NUM_RT = 2;
  localparam int RTA_W = 5;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int WOFF_W = 15;

  // Word offsets of the host-visible registers.
  localparam logic [WOFF_W-1:0] OFF_MCFG = 15'h0000;
  localparam logic [WOFF_W-1:0] OFF_OPSTAT0 = 15'h0010;
  localparam logic [WOFF_W-1:0] OFF_STBITS0 = 15'h0012;
  localparam logic [WOFF_W-1:0] OFF_MTSTAT = 15'h0014;
  localparam logic [WORD_W-1:0] MCFG_RST = 16'h0000;
  localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  typedef struct packed {
    logic [10:0] spare;
    logic irq_level_select;
    logic [NUM_RT-1:0] rt_start_exec;
    logic [NUM_RT-1:0] rt_enable_bit;
  } tdpc_mcfg_s;

  typedef struct packed {
    logic [8:0] spare;
    logic lock;
    logic parity;
    logic [RTA_W-1:0] addr;
  } tdpc_opstat_s;

  typedef struct packed {
    logic [14:0] spare;
    logic subsys_fail_bit;
  } tdpc_stbits_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } tdpc_hreq_s;

endpackage : tdpc_pkg

// File: core/tdpc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module tdpc_sync
  import tdpc_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // Two stages; the first stage feeds only the second.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : tdpc_sync
`default_nettype wire

// File: core/tdpc_rt.sv
`timescale 1ns/100ps
`default_nettype none
module tdpc_rt
  import tdpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mr_active_i,
  input wire logic mr_rise_i,
  input wire logic lock_s_i,
  input wire logic [RTA_W-1:0] addr_s_i,
  input wire logic parity_s_i,
  input wire logic ssf_s_i,
  input wire logic op_we_i,
  input wire logic sb_we_i,
  input wire logic [WORD_W-1:0] wdata_i,
  input wire logic mode_reset_i,
  input wire logic status_done_i,
  output tdpc_opstat_s opstat_o,
  output tdpc_stbits_s stbits_o,
  output logic ssf_o,
  output logic reset_cmd_n_o
);

  tdpc_opstat_s wr_raw;
  tdpc_opstat_s wr_op;
  tdpc_opstat_s strap_op;
  logic pend_q;
  logic fire;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic reset_n_d;

  // Host writes use the same field layout as reads, so a readback matches
  // what was written; reserved bits stay at zero.
  assign wr_raw = tdpc_opstat_s'(wdata_i);
  assign wr_op = '{spare: '0, lock: wr_raw.lock, parity: wr_raw.parity, addr: wr_raw.addr};
  assign strap_op = '{spare: '0, lock: lock_s_i, parity: parity_s_i, addr: addr_s_i};

  // Straps land at reset release; a locked register ignores the host.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opstat_o <= '0;
    end else if (mr_rise_i) begin
      opstat_o <= strap_op;
    end else if (op_we_i && !opstat_o.lock) begin
      opstat_o <= wr_op;
    end
  end

  // The status-bits register and the ORed fail flag.
  always_ff @(posedge clk_i) begin
    if (rst_i || mr_active_i) begin
      stbits_o <= '0;
      ssf_o <= 1'b0;
    end else begin
      if (sb_we_i) begin
        stbits_o <= '{spare: '0, subsys_fail_bit: wdata_i[0]};
      end
      ssf_o <= ssf_s_i | stbits_o.subsys_fail_bit;
    end
  end

  // The pulse fires when the status word of a reset command completes.
  assign fire = status_done_i && (pend_q || mode_reset_i);
  assign cnt_d = fire ? CNT_W'(RST_CMD_CYC - 1) : (cnt_q != CNT_ZERO) ? cnt_q - CNT_ONE : cnt_q;
  assign reset_n_d = fire ? 1'b0 : (cnt_q == CNT_ZERO) ? 1'b1 : reset_cmd_n_o;

  // Only the power-on reset touches this timer, so master reset
  // cannot cut a pulse short.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      cnt_q <= CNT_ZERO;
      reset_cmd_n_o <= 1'b1;
    end else begin
      pend_q <= (pend_q | mode_reset_i) & ~status_done_i;
      cnt_q <= cnt_d;
      reset_cmd_n_o <= reset_n_d;
    end
  end

endmodule : tdpc_rt
`default_nettype wire

// File: dv/tdpc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module tdpc_checker
  import tdpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic master_reset_n_i,
  input wire tdpc_hreq_s host_req_i,
  input wire logic host_ack_o,
  input wire logic irq_event_i,
  input wire logic irq_n_o,
  input wire logic mon_msg_busy_i,
  input wire logic mon_packet_done_i,
  input wire logic monitor_record_o,
  input wire logic monitor_packet_ready_o,
  input wire logic [NUM_RT-1:0] rt_enable_pin_i,
  input wire logic [NUM_RT-1:0] rt_enable_o,
  input wire logic [NUM_RT-1:0] rt_subsys_fail_in_i,
  input wire logic [NUM_RT-1:0] rt_subsys_fail_o,
  input wire logic [NUM_RT-1:0] rt_mode_reset_i,
  input wire logic [NUM_RT-1:0] rt_status_done_i,
  input wire logic [NUM_RT-1:0] rt_reset_cmd_out_n_o
);
  // All checks live in the one clock domain and pause during the synchronous reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Every request is answered exactly one cycle later, and nothing else is answered.
  property p_host_ack;
    !$past(rst_i) |-> host_ack_o == $past(host_req_i.req);
  endproperty
  a_host_ack: assert property (p_host_ack) else $error("host ack not one cycle after request");
  // Master reset is held off for four cycles because its synchroniser lags the pin.
  property p_rec_hold;
    (master_reset_n_i [*4]) ##0 (monitor_record_o && mon_msg_busy_i && !mon_packet_done_i)
      |=> monitor_record_o;
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("monitor stopped mid-message");
  property p_rdy_stop;
    $rose(monitor_packet_ready_o) |-> !monitor_record_o && $past(monitor_record_o);
  endproperty
  a_rdy_stop: assert property (p_rdy_stop) else $error("packet ready without monitor stop");
  property p_irq_fire;
    (master_reset_n_i [*4]) ##0 irq_event_i |=> !irq_n_o;
  endproperty
  a_irq_fire: assert property (p_irq_fire) else $error("event did not pull irq low");
  property p_irq_min;
    $fell(irq_n_o) |=> !irq_n_o [*8];
  endproperty
  a_irq_min: assert property (p_irq_min) else $error("irq low time too short");
  property p_rc_fire;
    rt_mode_reset_i[0] && rt_status_done_i[0] |=> !rt_reset_cmd_out_n_o[0] [*8];
  endproperty
  a_rc_fire: assert property (p_rc_fire) else $error("reset command pulse missing");
  // Ten cycles at 100 MHz is the 100 ns floor of the pulse.
  property p_rc_width;
    $rose(rt_reset_cmd_out_n_o[0]) && !$past(rst_i) |-> !$past(rt_reset_cmd_out_n_o[0], 10);
  endproperty
  a_rc_width: assert property (p_rc_width) else $error("reset command pulse too short");
  property p_ssf;
    rt_subsys_fail_in_i[1] [*4] |=> rt_subsys_fail_o[1];
  endproperty
  a_ssf: assert property (p_ssf) else $error("subsystem fail pin not passed on");
  property p_en;
    !rt_enable_pin_i[0] [*4] |=> !rt_enable_o[0];
  endproperty
  a_en: assert property (p_en) else $error("terminal enabled with pin low");
endmodule : tdpc_checker

bind tdpc_top tdpc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .master_reset_n_i(master_reset_n_i), .host_req_i(host_req_i), .host_ack_o(host_ack_o),
  .irq_event_i(irq_event_i), .irq_n_o(irq_n_o), .mon_msg_busy_i(mon_msg_busy_i),
  .mon_packet_done_i(mon_packet_done_i), .monitor_record_o(monitor_record_o),
  .monitor_packet_ready_o(monitor_packet_ready_o), .rt_enable_pin_i(rt_enable_pin_i),
  .rt_enable_o(rt_enable_o), .rt_subsys_fail_in_i(rt_subsys_fail_in_i),
  .rt_subsys_fail_o(rt_subsys_fail_o), .rt_mode_reset_i(rt_mode_reset_i),
  .rt_status_done_i(rt_status_done_i), .rt_reset_cmd_out_n_o(rt_reset_cmd_out_n_o));
`default_nettype wire

// File: dv/tdpc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module tdpc_host_model
  import tdpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [WORD_W-1:0] rdata_i,
  output tdpc_hreq_s req_o,
  output logic ack_pin_o,
  output logic hang_o
);
  initial begin
    req_o = '0;
    ack_pin_o = 1'b0;
    hang_o = 1'b0;
  end

  // One-cycle request pulse, since a held request would be taken twice; the answer
  // is taken at the rising edge at which the acknowledge is sampled high.
  task automatic xfer(input logic we, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    int i;
    @(posedge clk_i);
    req_o <= '{req: 1'b1, we: we, addr: a, wdata: d};
    @(posedge clk_i);
    req_o.req <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) break;
    end
    hang_o = (i == 4);
    q = rdata_i;
  endtask : xfer

  // Acknowledge held high for 26 cycles, a margin over the 250 ns minimum.
  task automatic ack_pulse();
    @(posedge clk_i);
    ack_pin_o <= 1'b1;
    repeat (26) @(posedge clk_i);
    ack_pin_o <= 1'b0;
  endtask : ack_pulse
endmodule : tdpc_host_model
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin @(negedge clk_i); tests_run++; if ((a) !== (b)) begin \
  error_cnt++; $display("MISMATCH t=%0t %s", $time, m); end end
module testbench
  import tdpc_pkg::*;
;
  logic clk_i, rst_i, mr_n, trig, run, bo, bw, spi, ev, busy, pdone, ack, hack, hang;
  logic trig_o, rec, rdy, irqn;
  logic [1:0] en, lock, par, ssf, mres, sdone, en_o, st_o, ssf_o, rcn;
  logic [1:0][4:0] adr, adr_o;
  logic [15:0] rdata;
  tdpc_hreq_s hreq;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h00000009;

  tdpc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .master_reset_n_i(mr_n), .bc_trigger_in_i(trig),
    .monitor_run_in_i(run), .irq_ack_in_i(ack), .byte_order_pin_i(bo), .bus_width_pin_i(bw),
    .rt_enable_pin_i(en), .rt_lock_pin_i(lock), .rt_address_pins_i(adr),
    .rt_addr_parity_pin_i(par), .rt_subsys_fail_in_i(ssf), .host_req_i(hreq),
    .host_spi_i(spi), .host_rdata_o(rdata), .host_ack_o(hack), .irq_event_i(ev),
    .mon_msg_busy_i(busy), .mon_packet_done_i(pdone), .rt_mode_reset_i(mres),
    .rt_status_done_i(sdone), .bc_trigger_o(trig_o), .monitor_record_o(rec),
    .monitor_packet_ready_o(rdy), .irq_n_o(irqn), .rt_enable_o(en_o), .rt_start_exec_o(st_o),
    .rt_address_o(adr_o), .rt_subsys_fail_o(ssf_o), .rt_reset_cmd_out_n_o(rcn));

  tdpc_host_model host (.clk_i(clk_i), .ack_i(hack), .rdata_i(rdata), .req_o(hreq),
    .ack_pin_o(ack), .hang_o(hang));

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd

  // The byte that travels at index idx for a given byte order.
  function automatic logic [7:0] nth_byte(input logic [15:0] w, input logic idx, input logic o);
    return (idx ^ o) ? w[15:8] : w[7:0];
  endfunction : nth_byte

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] q);
    host.xfer(1'b0, a, 16'h0000, q);
  endtask : rd

  // Counts low cycles of the interrupt (sel 0) or the first reset command (sel 1) over 60 cycles.
  task automatic lowlen(input int sel, output int n);
    n = 0;
    for (int i = 0; i < 60; i++) begin
      @(negedge clk_i);
      if ((sel == 1 ? rcn[0] : irqn) === 1'b0) n++;
    end
  endtask : lowlen

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // A request that is never answered ends the run as a failure.
  always @(posedge hang) begin
    error_cnt++;
    $display("MISMATCH t=%0t host request unanswered", $time);
    close_out();
  end

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Main sequence; straps are chosen before master reset is released.
  initial begin
    logic [15:0] q, v, w;
    int n;
    rst_i = 1'b1; mr_n = 1'b0; trig = 1'b0; run = 1'b0; bo = 1'b0; bw = 1'b1; spi = 1'b0;
    ev = 1'b0; busy = 1'b0; pdone = 1'b0; en = 2'b11; lock = 2'b10; ssf = 2'b00;
    mres = 2'b00; sdone = 2'b00;
    v = rnd();
    adr = {v[9:5], v[4:0]};
    par = {~^v[9:5], ~^v[4:0]};
    step(10);
    rst_i <= 1'b0;
    step(2);
    mr_n <= 1'b1;
    step(8);
    rd(16'h0020, w);
    `CHK(w[10:0], {lock[0], par[0], adr[0]}, "strap capture")
    rd(16'h0022, q);
    `CHK(q[6], 1'b1, "lock strap")
    step(1);
    adr <= ~adr;
    step(6);
    `CHK(adr_o, ~adr, "address ignores pins")
    v = rnd();
    v[6] = 1'b1;
    wr(16'h0020, v);
    rd(16'h0020, q);
    `CHK(q[6:0], v[6:0], "unlocked write")
    wr(16'h0020, ~v);
    rd(16'h0020, q);
    `CHK(q[6:0], v[6:0], "locked write")
    wr(16'h0022, v);
    rd(16'h0022, q);
    `CHK(q[4:0], ~adr[1], "strap-locked write")
    `CHK(adr_o[0], v[4:0], "address from register")
    $display("test opstat done");
    v = rnd();
    wr(16'h0000, v);
    rd(16'h0000, q);
    `CHK(q, v, "config readback")
    rd(16'h0100, q);
    `CHK(q, 16'h0000, "unmapped read")
    for (int k = 0; k < 16; k++) begin
      step(1);
      en <= k[1:0];
      wr(16'h0000, {14'h0000, k[3:2]});
      step(5);
      `CHK(en_o, k[1:0] & k[3:2], "combined enable")
    end
    // Start bits only after the enables are up.
    wr(16'h0000, 16'h0003);
    wr(16'h0000, 16'h000F);
    step(5);
    `CHK(st_o, 2'b11, "start bits")
    $display("test enable done");
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      w = rnd();
      step(1);
      bw <= 1'b1;
      spi <= 1'b0;
      step(4);
      wr(16'h0000, v);
      step(1);
      bo <= k[0];
      spi <= k[1];
      bw <= k[1];
      step(4);
      rd(16'h0000, q);
      `CHK(q, {8'h00, nth_byte(v, 1'b0, k[0])}, "first byte")
      rd(16'h0001, q);
      `CHK(q, {8'h00, nth_byte(v, 1'b1, k[0])}, "second byte")
      wr(16'h0000, {8'h00, nth_byte(w, 1'b0, k[0])});
      wr(16'h0001, {8'h00, nth_byte(w, 1'b1, k[0])});
      step(1);
      bw <= 1'b1;
      spi <= 1'b0;
      step(4);
      rd(16'h0000, q);
      `CHK(q, w, "byte pair word")
    end
    $display("test byte path done");
    wr(16'h0024, 16'h0001);
    step(5);
    `CHK(ssf_o, 2'b01, "fail bit")
    wr(16'h0024, 16'h0000);
    ssf <= 2'b10;
    step(6);
    `CHK(ssf_o, 2'b10, "fail pin")
    step(1);
    ssf <= 2'b00;
    trig <= 1'b1;
    step(4);
    `CHK(trig_o, 1'b1, "trigger high")
    step(1);
    trig <= 1'b0;
    run <= 1'b1;
    step(4);
    `CHK(trig_o, 1'b0, "trigger low")
    `CHK(rec, 1'b1, "recording")
    step(1);
    busy <= 1'b1;
    run <= 1'b0;
    step(8);
    `CHK(rec, 1'b1, "finish message")
    step(1);
    busy <= 1'b0;
    step(2);
    `CHK(rec, 1'b0, "stopped")
    step(1);
    run <= 1'b1;
    step(5);
    pdone <= 1'b1;
    step(1);
    pdone <= 1'b0;
    `CHK({rdy, rec}, 2'b10, "packet ready stops monitor")
    rd(16'h0028, q);
    `CHK(q[1:0], 2'b10, "status shows ready")
    step(1);
    run <= 1'b0;
    $display("test monitor done");
    wr(16'h0000, 16'h0000);
    step(1);
    ev <= 1'b1;
    step(1);
    ev <= 1'b0;
    lowlen(0, n);
    `CHK(n, IRQ_PULSE_CYC, "pulse interrupt")
    wr(16'h0000, 16'h0010);
    step(1);
    ev <= 1'b1;
    step(1);
    ev <= 1'b0;
    lowlen(0, n);
    `CHK(n, 60, "level interrupt holds")
    host.ack_pulse();
    step(6);
    `CHK(irqn, 1'b1, "level interrupt cleared")
    $display("test interrupt done");
    // Mode command first, status word completion three cycles later.
    step(1);
    mres <= 2'b01;
    step(1);
    mres <= 2'b00;
    step(2);
    sdone <= 2'b01;
    step(1);
    sdone <= 2'b00;
    lowlen(1, n);
    `CHK(n, RST_CMD_CYC, "reset command pulse")
    step(1);
    mres <= 2'b01;
    sdone <= 2'b01;
    step(1);
    mres <= 2'b00;
    sdone <= 2'b00;
    mr_n <= 1'b0;
    lowlen(1, n);
    step(1);
    mr_n <= 1'b1;
    `CHK(n, RST_CMD_CYC, "pulse under master reset")
    $display("test reset command done");
    close_out();
  end
endmodule : testbench
`undef CHK
`default_nettype wire
